// [src/tmc_consts.svh]
// Offsets, field positions, patterns and reset values of the capture channel.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH
// Register byte addresses
`define TMC_ADR_UNIT 8'h00
`define TMC_ADR_MODE 8'h04
`define TMC_ADR_TRIG 8'h08
`define TMC_ADR_ENST 8'h0C
`define TMC_ADR_COUNT 8'h10
`define TMC_ADR_DATA 8'h14
`define TMC_ADR_STAT 8'h18
`define TMC_ADR_OUT 8'h1C
`define TMC_ADR_NFEN 8'h20
// Single-bit positions
`define TMC_UNIT_EN_BIT 0
`define TMC_TRG_START_BIT 0
`define TMC_TRG_STOP_BIT 1
`define TMC_ENST_BIT 0
`define TMC_OVF_BIT 0
`define TMC_NFEN_BIT 0
`define TMC_MD_IRQ 0
`define TMC_MD_CCS 12
// Field positions of the mode and output registers
`define TMC_MD_OPM_HI 3
`define TMC_MD_OPM_LO 1
`define TMC_MD_EDGE_HI 7
`define TMC_MD_EDGE_LO 6
`define TMC_MD_TRIG_HI 10
`define TMC_MD_TRIG_LO 8
`define TMC_MD_CKS_HI 15
`define TMC_MD_CKS_LO 14
`define TMC_OUT_HI 3
// Field patterns
`define TMC_OPM_CAPT 3'h2
`define TMC_OPM_WIDTH 3'h6
`define TMC_EDGE_FALL 2'h0
`define TMC_EDGE_RISE 2'h1
`define TMC_EDGE_BOTH 2'h2
`define TMC_TRIG_EDGE_CAPT 3'h1
`define TMC_TRIG_EDGE_START 3'h2
`define TMC_CKS_P0 2'h0
`define TMC_CKS_P1 2'h2
`define TMC_CKS_P2 2'h1
`define TMC_CKS_P3 2'h3
// Counter values and reset values
`define TMC_CNT_ZERO 16'h0000
`define TMC_CNT_ONE 16'h0001
`define TMC_CNT_MAX 16'hFFFF
`define TMC_MODE_RST 16'h0000
`define TMC_OUT_RST 4'h0
`define TMC_RD_ZERO 16'h0000
`endif

// [src/tmc_pkg.sv]
// Types shared by the capture channel modules.
// Assumes the constants header is on the include path.
`include "tmc_consts.svh"
package tmc_pkg;
	// Channel sequencing, one-hot
	typedef enum logic [3:0] {
		TMC_IDLE = 4'h1,
		TMC_RUN = 4'h2,
		TMC_WAIT = 4'h4,
		TMC_MEAS = 4'h8
	} tmc_state_t;

	// Whole state of the channel core
	typedef struct packed {
		tmc_state_t state;
		logic unitEn;
		logic [15:0] mode;
		logic [3:0] outCtrl;
		logic nfen;
		logic enabled;
		logic clrPend;
		logic ovfPend;
		logic ovf;
		logic [15:0] count;
		logic [15:0] data;
		logic irq;
		logic [15:0] rdata;
	} tmc_core_t;

	// Whole state of the pin sampler
	typedef struct packed {
		logic level;
		logic tick;
		logic rise;
		logic fall;
	} tmc_smp_t;
endpackage

// [src/tmc_edge_if.sv]
// Carries the sampled operation clock tick and pin edges to the core.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
interface tmc_edge_if;
	logic tick;
	logic rise;
	logic fall;
	logic level;
	modport src (output tick, rise, fall, level);
	modport dst (input tick, rise, fall, level);
endinterface

// [src/tmc_edge_sampler.sv]
// Selects the operation clock enable and samples the input pin on it.
// Assumes prescaler enables are one-cycle pulses synchronous to clk.
`timescale 1ns/1ps
`include "tmc_consts.svh"
module tmc_edge_sampler
	import tmc_pkg::*;
#(
	parameter bit EXT_CLK_OK = 1'b1
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic unitEn,
	input wire logic pin,
	input wire logic [3:0] prescEn,
	input wire logic [1:0] clkSel,
	tmc_edge_if.src edge_o
);
	tmc_smp_t s_r;
	tmc_smp_t s_nxt;
	logic selTick;

	// Operation clock pick; outputs 2 and 3 exist only on some channels
	always_comb begin
		case (clkSel)
			`TMC_CKS_P0: selTick = prescEn[0];
			`TMC_CKS_P1: selTick = prescEn[1];
			`TMC_CKS_P2: selTick = EXT_CLK_OK & prescEn[2];
			`TMC_CKS_P3: selTick = EXT_CLK_OK & prescEn[3];
			default: selTick = 1'b0;
		endcase
	end

	// Pin sampled only on the tick, hence up to one tick of uncertainty
	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = selTick & unitEn;
		s_nxt.rise = 1'b0;
		s_nxt.fall = 1'b0;
		if (selTick && unitEn) begin
			s_nxt.level = pin;
			s_nxt.rise = pin & ~s_r.level;
			s_nxt.fall = ~pin & s_r.level;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign edge_o.tick = s_r.tick;
	assign edge_o.rise = s_r.rise;
	assign edge_o.fall = s_r.fall;
	assign edge_o.level = s_r.level;
endmodule

// [src/tmc_channel.sv]
// One 16-bit timer channel with interval and width capture functions.
// Assumes a register master on a plain strobe port and prescaler enables
// generated elsewhere as one-cycle pulses on clk.
`timescale 1ns/1ps
`include "tmc_consts.svh"

// Summary of operation
// - Mode pattern 010 gives free-running up count with capture.
// - Mode pattern 110 gives capture-and-one-count for width measurement.
// - Mode low bit 1 raises the interrupt at start; 0 does not.
// - Capture edge select: 00 falling, 01 rising, 10 both, 11 none.
// - Trigger select 001 makes a valid pin edge the capture trigger.
// - Trigger select 010 makes a valid pin edge start width counting.
// - Clock select 00,10,01,11 picks prescaler output 0,1,2,3.
// - Count source bit 0 counts operation clock ticks, not pin edges.
// - Start bit is self-clearing and sets the enabled status.
// - After start the count clears on the next tick, then counts up.
// - Edge or software start while running captures, clears, interrupts.
// - Each capture loads the overflow flag from the period's overflow.
// - Several wraps in one period still only set the flag.
// - Data, count and status reads never disturb operation.
// - Stop bit clears enabled status, holds count and overflow flag.
// - Unit disable resets the core state except the unit bit and read data, and blocks other register writes.
// - Width start sets enabled and waits for start edge, not counting.
// - Start edge clears the count and begins counting up.
// - Capture edge copies, interrupts, updates flag, halts at value+1.
// - Width edge select 10 measures low width, 11 high width.
// - The pin is sampled on the selected operation clock.
module tmc_channel
	import tmc_pkg::*;
#(
	parameter bit EXT_CLK_OK = 1'b1
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdata,
	input wire logic [3:0] prescEn,
	input wire logic capInPin,
	output logic chanIrq,
	output logic chanEnabled
);
	tmc_core_t st_r;
	tmc_core_t st_nxt;
	tmc_edge_if edgeBus ();
	logic [2:0] opMode;
	logic [1:0] edgeSel;
	logic [2:0] trigSel;
	logic capMode;
	logic widMode;
	logic validEdge;
	logic startEdge;
	logic captEdge;
	logic step;
	logic wrStart;
	logic wrStop;
	logic wrMode;
	logic capEvt;

	tmc_edge_sampler #(
		.EXT_CLK_OK(EXT_CLK_OK)
	) u_sampler (
		.clk(clk),
		.srst(srst),
		.unitEn(st_r.unitEn),
		.pin(capInPin),
		.prescEn(prescEn),
		.clkSel(st_r.mode[`TMC_MD_CKS_HI:`TMC_MD_CKS_LO]),
		.edge_o(edgeBus.src)
	);

	// Mode field decode
	assign opMode = st_r.mode[`TMC_MD_OPM_HI:`TMC_MD_OPM_LO];
	assign edgeSel = st_r.mode[`TMC_MD_EDGE_HI:`TMC_MD_EDGE_LO];
	assign trigSel = st_r.mode[`TMC_MD_TRIG_HI:`TMC_MD_TRIG_LO];
	assign capMode = (opMode == `TMC_OPM_CAPT);
	assign widMode = (opMode == `TMC_OPM_WIDTH);

	// Edge qualification; pattern 11 detects nothing in capture mode
	always_comb begin
		case (edgeSel)
			`TMC_EDGE_FALL: validEdge = edgeBus.fall;
			`TMC_EDGE_RISE: validEdge = edgeBus.rise;
			`TMC_EDGE_BOTH: validEdge = edgeBus.rise | edgeBus.fall;
			default: validEdge = 1'b0;
		endcase
	end

	// Width edges: select bit 0 high means high width, rise starts it
	assign startEdge = edgeSel[0] ? edgeBus.rise : edgeBus.fall;
	assign captEdge = edgeSel[0] ? edgeBus.fall : edgeBus.rise;

	// Count step comes from the tick unless pin edges are the source
	assign step = st_r.mode[`TMC_MD_CCS] ? validEdge : edgeBus.tick;

	// Register write strobes; only the unit bit is open while disabled
	assign wrStart = regWr && st_r.unitEn && (regAddr == `TMC_ADR_TRIG) &&
		regWdata[`TMC_TRG_START_BIT];
	assign wrStop = regWr && st_r.unitEn && (regAddr == `TMC_ADR_TRIG) &&
		regWdata[`TMC_TRG_STOP_BIT];
	assign wrMode = regWr && st_r.unitEn && (regAddr == `TMC_ADR_MODE);

	// Capture in interval mode: pin edge when selected, or software start
	assign capEvt = (st_r.state == TMC_RUN) && !st_r.clrPend && ((validEdge &&
		(trigSel == `TMC_TRIG_EDGE_CAPT)) || wrStart);

	// Next state of the whole channel
	always_comb begin
		st_nxt = st_r;
		st_nxt.irq = 1'b0;
		st_nxt.rdata = `TMC_RD_ZERO;
		// Configuration writes
		if (regWr && regAddr == `TMC_ADR_UNIT) begin
			st_nxt.unitEn = regWdata[`TMC_UNIT_EN_BIT];
		end
		if (wrMode) begin
			st_nxt.mode = regWdata;
		end
		if (regWr && st_r.unitEn && regAddr == `TMC_ADR_OUT) begin
			st_nxt.outCtrl = regWdata[`TMC_OUT_HI:0];
		end
		if (regWr && st_r.unitEn && regAddr == `TMC_ADR_NFEN) begin
			st_nxt.nfen = regWdata[`TMC_NFEN_BIT];
		end
		// Channel sequencing
		case (st_r.state)
			TMC_IDLE: begin
				if (wrStart) begin
					st_nxt.enabled = 1'b1;
					st_nxt.irq = st_r.mode[`TMC_MD_IRQ];
					if (capMode) begin
						st_nxt.state = TMC_RUN;
						st_nxt.clrPend = 1'b1;
						st_nxt.ovfPend = 1'b0;
					end else if (widMode) begin
						st_nxt.state = TMC_WAIT;
					end
				end
			end
			TMC_RUN: begin
				if (capEvt) begin
					st_nxt.data = st_r.count;
					st_nxt.count = `TMC_CNT_ZERO;
					st_nxt.irq = 1'b1;
					st_nxt.ovf = st_r.ovfPend;
					st_nxt.ovfPend = 1'b0;
				end else if (edgeBus.tick && st_r.clrPend) begin
					st_nxt.count = `TMC_CNT_ZERO;
					st_nxt.clrPend = 1'b0;
				end else if (step && !st_r.clrPend) begin
					st_nxt.count = st_r.count + `TMC_CNT_ONE;
					if (st_r.count == `TMC_CNT_MAX) begin
						st_nxt.ovfPend = 1'b1;
					end
				end
			end
			TMC_WAIT: begin
				if (startEdge && trigSel == `TMC_TRIG_EDGE_START) begin
					st_nxt.count = `TMC_CNT_ZERO;
					st_nxt.ovfPend = 1'b0;
					st_nxt.state = TMC_MEAS;
				end
			end
			TMC_MEAS: begin
				if (captEdge) begin
					st_nxt.data = st_r.count;
					st_nxt.count = st_r.count + `TMC_CNT_ONE;
					st_nxt.irq = 1'b1;
					st_nxt.ovf = st_r.ovfPend;
					st_nxt.state = TMC_WAIT;
				end else if (step) begin
					st_nxt.count = st_r.count + `TMC_CNT_ONE;
					if (st_r.count == `TMC_CNT_MAX) begin
						st_nxt.ovfPend = 1'b1;
					end
				end
			end
			default: begin
				st_nxt.state = TMC_IDLE;
			end
		endcase
		// Stop wins over everything else; count and flag are kept
		if (wrStop) begin
			st_nxt.enabled = 1'b0;
			st_nxt.state = TMC_IDLE;
			st_nxt.clrPend = 1'b0;
			st_nxt.count = st_r.count;
			st_nxt.data = st_r.data;
			st_nxt.ovf = st_r.ovf;
			st_nxt.irq = 1'b0;
		end
		// Read port is side-effect free, so reading never disturbs counting
		if (regRd) begin
			case (regAddr)
				`TMC_ADR_UNIT: st_nxt.rdata[`TMC_UNIT_EN_BIT] = st_r.unitEn;
				`TMC_ADR_MODE: st_nxt.rdata = st_r.mode;
				`TMC_ADR_ENST: st_nxt.rdata[`TMC_ENST_BIT] = st_r.enabled;
				`TMC_ADR_COUNT: st_nxt.rdata = st_r.count;
				`TMC_ADR_DATA: st_nxt.rdata = st_r.data;
				`TMC_ADR_STAT: st_nxt.rdata[`TMC_OVF_BIT] = st_r.ovf;
				`TMC_ADR_OUT: st_nxt.rdata[`TMC_OUT_HI:0] = st_r.outCtrl;
				`TMC_ADR_NFEN: st_nxt.rdata[`TMC_NFEN_BIT] = st_r.nfen;
				default: st_nxt.rdata = `TMC_RD_ZERO;
			endcase
		end
		// A disabled unit holds every core register except the unit bit and the read data at its reset value
		if (!st_r.unitEn) begin
			st_nxt.state = TMC_IDLE;
			st_nxt.mode = `TMC_MODE_RST;
			st_nxt.outCtrl = `TMC_OUT_RST;
			st_nxt.nfen = 1'b0;
			st_nxt.enabled = 1'b0;
			st_nxt.clrPend = 1'b0;
			st_nxt.ovfPend = 1'b0;
			st_nxt.ovf = 1'b0;
			st_nxt.count = `TMC_CNT_ZERO;
			st_nxt.data = `TMC_CNT_ZERO;
			st_nxt.irq = 1'b0;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= '{state: TMC_IDLE, mode: `TMC_MODE_RST,
				outCtrl: `TMC_OUT_RST, count: `TMC_CNT_ZERO,
				data: `TMC_CNT_ZERO, rdata: `TMC_RD_ZERO, default: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign regRdata = st_r.rdata;
	assign chanIrq = st_r.irq;
	assign chanEnabled = st_r.enabled;

	// Start from idle enables the channel on the next edge
	AST_START_SETS_EN: assert property (@(posedge clk)
		disable iff (srst)
		wrStart && !wrStop && st_r.state == TMC_IDLE |=> st_r.enabled)
		else $error("start did not enable channel");

	// Start interrupt follows the mode low bit exactly
	AST_START_IRQ: assert property (@(posedge clk) disable iff (srst)
		wrStart && !wrStop && st_r.state == TMC_IDLE && capMode |=>
		chanIrq == $past(st_r.mode[`TMC_MD_IRQ]))
		else $error("start interrupt wrong");

	// Stop halts, keeps count and overflow flag
	AST_STOP_HOLDS: assert property (@(posedge clk) disable iff (srst)
		wrStop |=> !st_r.enabled && st_r.count == $past(st_r.count) &&
		st_r.ovf == $past(st_r.ovf) && st_r.state == TMC_IDLE)
		else $error("stop did not hold state");

	// Capture copies count, clears it and interrupts
	AST_CAPT_COPY: assert property (@(posedge clk) disable iff (srst)
		capEvt && !wrStop && st_r.unitEn |=> st_r.data == $past(st_r.count) &&
		st_r.count == `TMC_CNT_ZERO && chanIrq)
		else $error("capture did not copy and clear");

	// Wrap sets the pending overflow that the next capture reports
	AST_OVF_WRAP: assert property (@(posedge clk) disable iff (srst)
		st_r.state == TMC_RUN && !capEvt && !st_r.clrPend && step &&
		st_r.count == `TMC_CNT_MAX && !wrStop && st_r.unitEn |=>
		st_r.ovfPend && st_r.count == `TMC_CNT_ZERO)
		else $error("wrap did not mark overflow");

	// Width capture halts at captured value plus one and waits
	AST_WIDTH_HALT: assert property (@(posedge clk) disable iff (srst)
		st_r.state == TMC_MEAS && captEdge && !wrStop && st_r.unitEn |=>
		st_r.count == st_r.data + `TMC_CNT_ONE && st_r.state == TMC_WAIT &&
		chanIrq ##1 !chanIrq)
		else $error("width capture did not halt");

	// Waiting for start edge leaves the counter still
	AST_WAIT_STILL: assert property (@(posedge clk) disable iff (srst)
		st_r.state == TMC_WAIT && !startEdge && st_r.unitEn |=>
		$stable(st_r.count))
		else $error("counter moved while waiting");

	// Unit disable clears the channel within one cycle
	AST_UNIT_OFF: assert property (@(posedge clk) disable iff (srst)
		!st_r.unitEn |=> !st_r.enabled && st_r.count == `TMC_CNT_ZERO &&
		st_r.mode == `TMC_MODE_RST)
		else $error("disabled unit not cleared");

	// Read data appear only in the cycle after a read strobe
	AST_READ_SLOT: assert property (@(posedge clk) disable iff (srst)
		!regRd |=> regRdata == `TMC_RD_ZERO)
		else $error("read data outside slot");

	// Clearing tick after start zeroes the count exactly once
	AST_CLR_TICK: assert property (@(posedge clk)
		disable iff (srst) st_r.state == TMC_RUN && st_r.clrPend &&
		edgeBus.tick && !wrStop && st_r.unitEn |=>
		st_r.count == `TMC_CNT_ZERO && !st_r.clrPend)
		else $error("clearing tick did not zero count");

	// Free-running count moves up by one per step
	AST_RUN_STEP: assert property (@(posedge clk)
		disable iff (srst) st_r.state == TMC_RUN && !st_r.clrPend &&
		!capEvt && step && !wrStop && st_r.unitEn |=>
		st_r.count == $past(st_r.count) + `TMC_CNT_ONE)
		else $error("running count did not step");

	// Interval capture reports the overflow of its own period
	AST_CAPT_OVF: assert property (@(posedge clk)
		disable iff (srst) capEvt && !wrStop && st_r.unitEn |=>
		st_r.ovf == $past(st_r.ovfPend))
		else $error("capture overflow flag wrong");

	// Start edge clears the count and enters measurement
	AST_WAIT_START: assert property (@(posedge clk)
		disable iff (srst) st_r.state == TMC_WAIT && startEdge &&
		trigSel == `TMC_TRIG_EDGE_START && !wrStop && st_r.unitEn |=>
		st_r.state == TMC_MEAS && st_r.count == `TMC_CNT_ZERO)
		else $error("start edge did not begin measurement");

	// Width count moves up by one per step until the capture edge
	AST_MEAS_STEP: assert property (@(posedge clk)
		disable iff (srst) st_r.state == TMC_MEAS && !captEdge && step &&
		!wrStop && st_r.unitEn |=>
		st_r.count == $past(st_r.count) + `TMC_CNT_ONE)
		else $error("width count did not step");

	// Width capture also reports the overflow of its period
	AST_WIDTH_OVF: assert property (@(posedge clk)
		disable iff (srst) st_r.state == TMC_MEAS && captEdge &&
		!wrStop && st_r.unitEn |=>
		st_r.ovf == $past(st_r.ovfPend))
		else $error("width overflow flag wrong");

	// Trigger bits are write-only strobes and always read as zero
	AST_TRIG_READ: assert property (@(posedge clk)
		disable iff (srst) regRd && regAddr == `TMC_ADR_TRIG |=>
		regRdata == `TMC_RD_ZERO)
		else $error("trigger bits did not read as zero");

	// A disabled unit ignores mode writes
	AST_WR_BLOCKED: assert property (@(posedge clk)
		disable iff (srst) regWr && !st_r.unitEn &&
		regAddr == `TMC_ADR_MODE |=> st_r.mode == `TMC_MODE_RST)
		else $error("write landed while unit disabled");
endmodule

// [tb/tmc_pin_model.sv]
// Partner model: the external pulse source on the timer input pin.
// Assumes its task is called from the bench right after a rising edge.
`timescale 1ns/1ps
module tmc_pin_model (
	input wire logic clk,
	output logic pin
);
	// The source idles low and holds its level between edges
	initial begin
		pin = 1'b0;
	end

	// Hold the level n cycles, then flip it; callers keep n above the
	// selected tick period so no edge is lost between two samples
	task automatic toggle(input int n);
		repeat (n) @(posedge clk);
		pin <= ~pin;
	endtask
endmodule

// [tb/tb_timer_channel_capture_measure.sv]
// Self-checking bench for the capture channel: interval and width runs.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`include "tmc_consts.svh"
module tb_timer_channel_capture_measure;
	logic clk = 1'b0;
	logic srst;
	logic regWr;
	logic regRd;
	logic chanIrq;
	logic chanEnabled;
	logic capInPin;
	logic [7:0] regAddr;
	logic [15:0] regWdata;
	logic [15:0] regRdata;
	logic [3:0] prescEn = 4'h0;
	logic [2:0] pre = 3'h0;
	int errCount = 0;
	int checks = 0;
	int irqs = 0;
	int cyc = 0;

	tmc_channel #(.EXT_CLK_OK(1'b1)) i_tmc_channel (
		.clk(clk),
		.srst(srst),
		.regAddr(regAddr),
		.regWdata(regWdata),
		.regWr(regWr),
		.regRd(regRd),
		.regRdata(regRdata),
		.prescEn(prescEn),
		.capInPin(capInPin),
		.chanIrq(chanIrq),
		.chanEnabled(chanEnabled)
	);

	tmc_pin_model i_tmc_pin_model (
		.clk(clk),
		.pin(capInPin)
	);

	// 40 MHz clock
	always #12.5 clk = ~clk;

	// Prescaler pulses: every 1, 4, 2 and 8 cycles on outputs 0..3
	always @(posedge clk) begin
		pre <= pre + 3'h1;
		prescEn <= {pre == 3'h7, pre[0], pre[1:0] == 2'h3, 1'b1};
	end

	// Count interrupt pulses; a hang past the ceiling ends the run
	always @(posedge clk) begin
		if (chanIrq === 1'b1)
			irqs <= irqs + 1;
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			errCount++;
			complete_run();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			errCount++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		if (errCount == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Register write: one strobe cycle, then one idle cycle
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		@(posedge clk);
	endtask

	// Register read: data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(negedge clk);
		v = regRdata;
		@(posedge clk);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] v;
		rd(a, v);
		check(v, exp);
	endtask

	// Interval run: four pin flips 40 cycles apart, then stop
	task automatic interval(input logic [1:0] ed, input logic [1:0] ck,
			input logic sirq, input logic [15:0] expD, input int expI);
		logic [15:0] m;
		logic [15:0] v;
		int i0;
		m = {ck, 6'h01, ed, 2'h0, 3'h2, sirq};
		wr(`TMC_ADR_MODE, m);
		i0 = irqs;
		wr(`TMC_ADR_TRIG, 16'h0001);
		rdc(`TMC_ADR_ENST, 16'h0001);
		rdc(`TMC_ADR_TRIG, 16'h0000);
		check({15'h0000, chanEnabled}, 16'h0001);
		repeat (4) i_tmc_pin_model.toggle(40);
		repeat (12) @(posedge clk);
		rdc(`TMC_ADR_DATA, expD);
		check(16'(irqs - i0), 16'(expI));
		if (sirq) begin
			i0 = irqs;
			wr(`TMC_ADR_TRIG, 16'h0001);
			repeat (3) @(posedge clk);
			check(16'(irqs - i0), 16'h0001);
		end
		wr(`TMC_ADR_TRIG, 16'h0002);
		rdc(`TMC_ADR_ENST, 16'h0000);
		check({15'h0000, chanEnabled}, 16'h0000);
		rd(`TMC_ADR_COUNT, v);
		repeat (20) @(posedge clk);
		rdc(`TMC_ADR_COUNT, v);
	endtask

	// Main sequence
	initial begin
		logic [15:0] v;
		int i0;
		srst = 1'b1;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 8'h00;
		regWdata = 16'h0000;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		// Reset values and setup; output bits stay 0 for capture use
		wr(`TMC_ADR_UNIT, 16'h0001);
		rdc(`TMC_ADR_MODE, 16'h0000);
		rdc(`TMC_ADR_COUNT, 16'h0000);
		rdc(`TMC_ADR_STAT, 16'h0000);
		wr(`TMC_ADR_OUT, 16'h0000);
		wr(`TMC_ADR_NFEN, 16'h0001);
		rdc(`TMC_ADR_NFEN, 16'h0001);
		rdc(8'h24, 16'h0000);
		// Edge kinds and clock choices; edge pattern 11 detects nothing
		interval(2'h0, 2'h0, 1'b1, 16'h004F, 3);
		interval(2'h1, 2'h2, 1'b0, 16'h0013, 2);
		interval(2'h2, 2'h1, 1'b0, 16'h0013, 4);
		interval(2'h3, 2'h1, 1'b0, 16'h0013, 0);
		interval(2'h2, 2'h3, 1'b0, 16'h0004, 4);
		// Overflow: falls 65546 ticks apart wrap once
		wr(`TMC_ADR_MODE, {2'h0, 6'h01, 2'h0, 2'h0, 3'h2, 1'b0});
		wr(`TMC_ADR_TRIG, 16'h0001);
		i_tmc_pin_model.toggle(4);
		i_tmc_pin_model.toggle(4);
		i_tmc_pin_model.toggle(8);
		i_tmc_pin_model.toggle(65538);
		repeat (6) @(posedge clk);
		rdc(`TMC_ADR_DATA, 16'h0009);
		rdc(`TMC_ADR_STAT, 16'h0001);
		wr(`TMC_ADR_TRIG, 16'h0002);
		rdc(`TMC_ADR_STAT, 16'h0001);
		wr(`TMC_ADR_TRIG, 16'h0001);
		i_tmc_pin_model.toggle(4);
		i_tmc_pin_model.toggle(4);
		i_tmc_pin_model.toggle(4);
		i_tmc_pin_model.toggle(16);
		repeat (6) @(posedge clk);
		rdc(`TMC_ADR_DATA, 16'h0013);
		rdc(`TMC_ADR_STAT, 16'h0000);
		wr(`TMC_ADR_TRIG, 16'h0002);
		// High width of 30 ticks; start is only issued while stopped
		wr(`TMC_ADR_MODE, {2'h0, 6'h02, 2'h3, 2'h0, 3'h6, 1'b0});
		i0 = irqs;
		wr(`TMC_ADR_TRIG, 16'h0001);
		rd(`TMC_ADR_COUNT, v);
		repeat (10) @(posedge clk);
		rdc(`TMC_ADR_COUNT, v);
		rdc(`TMC_ADR_ENST, 16'h0001);
		check(16'(irqs - i0), 16'h0000);
		i_tmc_pin_model.toggle(4);
		i_tmc_pin_model.toggle(30);
		repeat (6) @(posedge clk);
		rdc(`TMC_ADR_DATA, 16'h001D);
		rdc(`TMC_ADR_COUNT, 16'h001E);
		check(16'(irqs - i0), 16'h0001);
		repeat (10) @(posedge clk);
		rdc(`TMC_ADR_COUNT, 16'h001E);
		// Low width of 25 ticks: the rise while waiting must not count
		wr(`TMC_ADR_TRIG, 16'h0002);
		wr(`TMC_ADR_MODE, {2'h0, 6'h02, 2'h2, 2'h0, 3'h6, 1'b0});
		wr(`TMC_ADR_TRIG, 16'h0001);
		i_tmc_pin_model.toggle(4);
		i_tmc_pin_model.toggle(4);
		i_tmc_pin_model.toggle(25);
		repeat (6) @(posedge clk);
		rdc(`TMC_ADR_DATA, 16'h0018);
		rdc(`TMC_ADR_COUNT, 16'h0019);
		// Pin edges as count source, software capture; edge bits changed
		// while running, the only change allowed then
		wr(`TMC_ADR_TRIG, 16'h0002);
		wr(`TMC_ADR_MODE, {2'h0, 6'h10, 2'h2, 2'h0, 3'h2, 1'b0});
		wr(`TMC_ADR_TRIG, 16'h0001);
		repeat (2) i_tmc_pin_model.toggle(4);
		wr(`TMC_ADR_MODE, {2'h0, 6'h10, 2'h1, 2'h0, 3'h2, 1'b0});
		repeat (2) i_tmc_pin_model.toggle(4);
		repeat (6) @(posedge clk);
		rdc(`TMC_ADR_COUNT, 16'h0003);
		wr(`TMC_ADR_TRIG, 16'h0001);
		rdc(`TMC_ADR_DATA, 16'h0003);
		rdc(`TMC_ADR_COUNT, 16'h0000);
		// Unit disable clears state and blocks writes
		wr(`TMC_ADR_UNIT, 16'h0000);
		rdc(`TMC_ADR_DATA, 16'h0000);
		rdc(`TMC_ADR_ENST, 16'h0000);
		wr(`TMC_ADR_MODE, 16'h1234);
		wr(`TMC_ADR_UNIT, 16'h0001);
		rdc(`TMC_ADR_MODE, 16'h0000);
		complete_run();
	end
endmodule
